// file: logic/adcsf_params.svh
// Constants for the converter status flag block.
// Assumes inclusion by its bare name from the package and the design.
`ifndef ADCSF_PARAMS_SVH
`define ADCSF_PARAMS_SVH

// Status register bit positions
`define ADCSF_BIT_CAL        15
`define ADCSF_BIT_AUX_ERR    13
`define ADCSF_BIT_PRIM_ERR   12
`define ADCSF_BIT_ACC_THR    6
`define ADCSF_BIT_CMP        4
`define ADCSF_BIT_OVR        3
`define ADCSF_BIT_AUX_RDY    1
`define ADCSF_BIT_PRIM_RDY   0
`define ADCSF_STATUS_RESET   16'h0000

// Widths of results, accumulator and threshold counter
`define ADCSF_RES_W          24
`define ADCSF_ACC_W          32
`define ADCSF_CNT_W          16
`define ADCSF_MASK_W         8

// Full-scale clamp values of a 24-bit two's complement result
`define ADCSF_POS_FS         24'h7fffff
`define ADCSF_NEG_FS         24'h800000

// Overrange evaluation period
`define ADCSF_CLK_MHZ        10
`define ADCSF_OVR_PERIOD_US  125
`define ADCSF_OVR_CYCLES     (`ADCSF_OVR_PERIOD_US * `ADCSF_CLK_MHZ)
`define ADCSF_OVR_CNT_W      11

`endif

// file: logic/adcsf_pkg.sv
// Types shared by the converter status flag block.
// Assumes the constants header is on the include path.
`include "adcsf_params.svh"

package adcsf_pkg;

    // One conversion event from a converter datapath
    typedef struct packed {
        logic                      valid;
        logic                      over;
        logic                      under;
        logic [`ADCSF_RES_W-1:0]   data;
    } adcsf_conv_s;

    // Comparator settings taken from the configuration registers
    typedef struct packed {
        logic                      comp_enable;
        logic                      count_enable;
        logic [`ADCSF_RES_W-1:0]   comp_threshold;
        logic [`ADCSF_CNT_W-1:0]   count_limit;
    } adcsf_cmp_cfg_s;

    typedef logic [`ADCSF_RES_W-1:0] adcsf_res_t;

endpackage

// file: logic/adcsf_status.sv
// Status flag logic of a dual sigma-delta converter subsystem.
// Assumes single-cycle event pulses from the converter datapaths and
// register strobes from the processor bus, all on ref_clk; only the
// gross overrange level arrives from the analog side unsynchronised.
//
// Notes on behaviour
// - Calibration finish sets status bit 15
// - Mode register write clears calibration flag
// - Aux out of range: flag 13, clamp
// - In-range aux result written clears flag 13
// - Primary out of range: flag 12, clamp
// - In-range primary result written clears flag 12
// - Bit 6 follows accumulator above its threshold
// - Comparator flag only while comparator enabled
// - No counter: flag on magnitude above threshold
// - Counter: flag when count equals limit
// - Enabled overrange detect sets bit 3
// - Overrange flag evaluated every 125 us
// - Overrange flag sticks until disable or gain change
// - Aux enabled: bit 1 on result write
// - Calibration end sets both ready flags
// - Aux ready clears on aux then primary read
// - Primary enabled: bit 0 on result write
// - Hold result writes until ready flag cleared, except while core powered down
// - Interrupt only for masked-in status bits
`timescale 1ns/10ps
`include "adcsf_params.svh"

module adcsf_status (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  adcsf_pkg::adcsf_conv_s       prim_conv,
    input  adcsf_pkg::adcsf_conv_s       aux_conv,
    input  wire logic                    prim_enable,
    input  wire logic                    aux_enable,
    input  wire logic                    cal_done,
    input  wire logic                    mode_reg_write,
    input  wire logic                    aux_result_read,
    input  wire logic                    primary_result_read,
    input  wire logic                    core_powered_down,
    input  adcsf_pkg::adcsf_cmp_cfg_s    cmp_cfg,
    input  wire logic [31:0]             primary_accumulator,
    input  wire logic [31:0]             accumulator_threshold_reg,
    input  wire logic                    ovr_detect_enable,
    input  wire logic                    gain_change,
    input  wire logic                    gross_overrange_in,
    input  wire logic [7:0]              converter_irq_mask,
    output logic [15:0]                  converter_status,
    output adcsf_pkg::adcsf_res_t        primary_result_reg,
    output adcsf_pkg::adcsf_res_t        aux_result_reg,
    output logic [15:0]                  threshold_counter_value,
    output logic                         converter_irq
);
    import adcsf_pkg::*;

    // Last count of the overrange evaluation period
    localparam logic [`ADCSF_OVR_CNT_W-1:0] OVR_LAST =
        `ADCSF_OVR_CNT_W'(`ADCSF_OVR_CYCLES - 1);

    // Clamp an out-of-range result to the matching full-scale extreme
    function automatic adcsf_res_t clamp_res(input adcsf_conv_s c);
        adcsf_res_t r;
        r = c.data;
        if (c.over) begin
            r = `ADCSF_POS_FS;
        end else if (c.under) begin
            r = `ADCSF_NEG_FS;
        end
        return r;
    endfunction

    // Magnitude of a signed result; negative full scale saturates
    function automatic adcsf_res_t mag_res(input adcsf_res_t v);
        adcsf_res_t m;
        m = v;
        if (v[`ADCSF_RES_W-1]) begin
            m = adcsf_res_t'(~v + 24'h000001);
            if (m[`ADCSF_RES_W-1]) begin
                m = `ADCSF_POS_FS;
            end
        end
        return m;
    endfunction

    // Flag flops, synchroniser stages, period timer and write strobes
    logic       cal_flag;
    logic       aux_err;
    logic       prim_err;
    logic       acc_flag;
    logic       cmp_flag;
    logic       ovr_flag;
    logic       aux_rdy;
    logic       prim_rdy;
    logic       aux_read_seen;
    logic       ovr_s1;
    logic       ovr_s2;
    logic       ovr_s3;
    logic       ovr_level;
    logic [`ADCSF_OVR_CNT_W-1:0] ovr_cnt;
    logic       ovr_tick;
    logic       prim_wr;
    logic       aux_wr;
    logic       prim_exceed;
    logic [15:0] next_count;
    adcsf_res_t prim_clamped;
    adcsf_res_t aux_clamped;

    // A new result only lands once software has taken the last one,
    // except with the core asleep, where the newest result wins
    assign prim_wr = prim_conv.valid
                   & (~prim_rdy | core_powered_down);
    assign aux_wr  = aux_conv.valid
                   & (~aux_rdy | core_powered_down);

    // Clamped once; the primary value is shared by the result store and the comparator
    assign prim_clamped = clamp_res(prim_conv);
    assign aux_clamped  = clamp_res(aux_conv);

    // Result registers hold the clamped value
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_result_reg <= '0;
            aux_result_reg     <= '0;
        end else begin
            if (prim_wr) begin
                primary_result_reg <= prim_clamped;
            end
            if (aux_wr) begin
                aux_result_reg <= aux_clamped;
            end
        end
    end

    // Calibration flag; a finish in the same cycle as a mode write wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_flag <= 1'b0;
        end else if (cal_done) begin
            cal_flag <= 1'b1;
        end else if (mode_reg_write) begin
            cal_flag <= 1'b0;
        end
    end

    // Conversion error flags follow each result actually written
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prim_err <= 1'b0;
            aux_err  <= 1'b0;
        end else begin
            if (prim_wr) begin
                // Set on out of range, cleared by an in-range result
                prim_err <= prim_conv.over
                          | prim_conv.under;
            end
            if (aux_wr) begin
                aux_err <= aux_conv.over
                         | aux_conv.under;
            end
        end
    end

    // Accumulator level compare, refreshed every cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_flag <= 1'b0;
        end else begin
            acc_flag <= $signed(primary_accumulator)
                      > $signed(accumulator_threshold_reg);
        end
    end

    // Comparator magnitude test on every primary conversion
    assign prim_exceed = mag_res(prim_clamped) > cmp_cfg.comp_threshold;

    // Counter saturates at the limit so the flag does not wrap away
    always_comb begin
        next_count = threshold_counter_value;
        if (prim_exceed
            && threshold_counter_value != cmp_cfg.count_limit) begin
            next_count = threshold_counter_value + 16'h0001;
        end
    end

    // Threshold counter runs only while comparator and counter are on
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            threshold_counter_value <= '0;
        end else if (!cmp_cfg.comp_enable || !cmp_cfg.count_enable) begin
            threshold_counter_value <= '0;
        end else if (prim_conv.valid) begin
            threshold_counter_value <= next_count;
        end
    end

    // Comparator flag; forced low while the comparator is off
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_flag <= 1'b0;
        end else if (!cmp_cfg.comp_enable) begin
            cmp_flag <= 1'b0;
        end else if (prim_conv.valid) begin
            if (cmp_cfg.count_enable) begin
                cmp_flag <= next_count == cmp_cfg.count_limit;
            end else begin
                cmp_flag <= prim_exceed;
            end
        end
    end

    // Overrange level comes from the analog side: three stages,
    // accepted only when the second and third agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_s1    <= 1'b0;
            ovr_s2    <= 1'b0;
            ovr_s3    <= 1'b0;
            ovr_level <= 1'b0;
        end else begin
            ovr_s1 <= gross_overrange_in;
            ovr_s2 <= ovr_s1;
            ovr_s3 <= ovr_s2;
            if (ovr_s2 == ovr_s3) begin
                ovr_level <= ovr_s3;
            end
        end
    end

    // Evaluation period timer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_cnt <= '0;
        end else if (ovr_cnt == OVR_LAST) begin
            ovr_cnt <= '0;
        end else begin
            ovr_cnt <= ovr_cnt + 11'h001;
        end
    end

    // One-cycle pulse that closes each evaluation period
    assign ovr_tick = ovr_cnt == OVR_LAST;

    // Sticky overrange flag; a set at the tick beats a gain change
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_flag <= 1'b0;
        end else if (ovr_detect_enable && ovr_tick && ovr_level) begin
            ovr_flag <= 1'b1;
        end else if (!ovr_detect_enable || gain_change) begin
            ovr_flag <= 1'b0;
        end
    end

    // Remembers that the aux result was read since the last clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_read_seen <= 1'b0;
        end else if (primary_result_read) begin
            aux_read_seen <= 1'b0;
        end else if (aux_result_read) begin
            aux_read_seen <= 1'b1;
        end
    end

    // Ready flags; any set beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prim_rdy <= 1'b0;
            aux_rdy  <= 1'b0;
        end else begin
            if (cal_done || (prim_wr && prim_enable)) begin
                prim_rdy <= 1'b1;
            end else if (primary_result_read) begin
                prim_rdy <= 1'b0;
            end
            if (cal_done || (aux_wr && aux_enable)) begin
                aux_rdy <= 1'b1;
            end else if (primary_result_read && aux_read_seen) begin
                // Primary read is needed even with primary disabled
                aux_rdy <= 1'b0;
            end
        end
    end

    // Status word; reserved positions tie low, no write path exists
    assign converter_status = {cal_flag, 1'b0, aux_err, prim_err,
                               5'h00, acc_flag, 1'b0, cmp_flag,
                               ovr_flag, 1'b0, aux_rdy, prim_rdy};

    // Interrupt registered from the masked low status byte,
    // so it trails the flags by one cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_irq <= 1'b0;
        end else begin
            converter_irq <= |(converter_status[7:0]
                             & converter_irq_mask);
        end
    end

endmodule

// file: sim/adcsf_status_properties.sv
// Port assertions for the converter status flag block.
// Assumes a bind into adcsf_status; one clock, async active-low reset.
`timescale 1ns/10ps
module adcsf_status_properties (
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire logic           prim_enable,
    input  adcsf_pkg::adcsf_conv_s prim_conv,
    input  adcsf_pkg::adcsf_conv_s aux_conv,
    input  wire logic           cal_done,
    input  wire logic           mode_reg_write,
    input  wire logic           aux_result_read,
    input  wire logic           primary_result_read,
    input  wire logic           core_powered_down,
    input  wire logic [31:0]    primary_accumulator,
    input  wire logic [31:0]    accumulator_threshold_reg,
    input  wire logic [7:0]     converter_irq_mask,
    input  wire logic [15:0]    converter_status,
    input  adcsf_pkg::adcsf_res_t primary_result_reg,
    input  wire logic           converter_irq
);
    import adcsf_pkg::*;
    wire [15:0] st = converter_status;
    wire        p_ok = prim_conv.valid && (!st[0] || core_powered_down);
    // Rising edge throughout; rst_n in antecedents skips the release edge
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    cal_set_a: assert property (
        cal_done |=> st[15] && st[1] && st[0]) else $error("cal flags low");
    cal_clear_a: assert property (
        mode_reg_write && !cal_done |=> !st[15]) else $error("cal flag kept");
    reserved_zero_a: assert property (
        (st & 16'h4fa4) == 16'h0000) else $error("reserved bit set");
    prim_clamp_a: assert property (
        p_ok && prim_conv.over |=> primary_result_reg == 24'h7fffff
        && st[12] && (st[0] || !prim_enable))
        else $error("overrange not clamped");
    prim_err_clear_a: assert property (
        p_ok && !prim_conv.over && !prim_conv.under |=> !st[12]
        && primary_result_reg == $past(prim_conv.data))
        else $error("bad result");
    acc_flag_a: assert property (
        rst_n |=> st[6] == ($signed($past(primary_accumulator))
        > $signed($past(accumulator_threshold_reg)))) else $error("acc flag");
    irq_mask_a: assert property (
        rst_n |=> converter_irq
        == |($past(st[7:0]) & $past(converter_irq_mask)))
        else $error("irq mismatch");
    aux_rdy_clear_a: assert property (
        aux_result_read && !primary_result_read ##1 primary_result_read
        && !aux_result_read && !aux_conv.valid && !cal_done |=> !st[1])
        else $error("aux ready kept");
    cover property (p_ok && prim_conv.under);
    cover property (aux_result_read ##1 primary_result_read);
    cover property (cal_done);
endmodule
bind adcsf_status adcsf_status_properties u_props (.*);

// file: sim/test_adcsf_status.sv
// Self-checking bench for the converter status flag block.
// Assumes the package, the design and its checker are compiled first.
`timescale 1ns/10ps
module test_adcsf_status;
    import adcsf_pkg::*;
    logic           ref_clk, rst_n, cal_done, mode_reg_write, gain_change;
    logic           aux_result_read, primary_result_read, core_powered_down;
    logic           ovr_detect_enable, gross_overrange_in, converter_irq;
    logic           prim_enable, aux_enable;
    adcsf_conv_s    prim_conv, aux_conv, pv, av;
    adcsf_cmp_cfg_s cmp_cfg;
    logic [31:0]    primary_accumulator, accumulator_threshold_reg, r, q;
    logic [15:0]    converter_status, threshold_counter_value, es, ps;
    logic [7:0]     converter_irq_mask;
    adcsf_res_t     primary_result_reg, aux_result_reg, mpr, mar;
    integer         seed = 25279, fail_count = 0, num_checks = 0;
    integer         cyc = 0, t0, n, p, cnt;
    logic           pr, ar, pe, ae, cal, cmp, seen, ex, wp, wa;
    // Channel enables follow the phase so both ready paths get exercised
    adcsf_status u_dut (.*);
    // Clock and a cycle count for period checks
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    task automatic chk(input logic [31:0] sv, input logic [31:0] ev);
        num_checks++;
        if (sv !== ev) begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, sv, ev);
            fail_count++;
        end
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Over wins over under; in range passes the data through
    function automatic adcsf_res_t clamp(input logic [25:0] c);
        return c[25] ? 24'h7fffff : c[24] ? 24'h800000 : c[23:0];
    endfunction
    // Sign-free size; the negative extreme has no positive twin
    function automatic adcsf_res_t mag(input adcsf_res_t d);
        return d == 24'h800000 ? 24'h7fffff : d[23] ? -d : d;
    endfunction
    // Two cycles of reset, comparator mode follows the phase
    task automatic rst_seq;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cmp_cfg <= {p != 2, p == 1, 24'h0, 16'h0003};
        {prim_enable, aux_enable} <= {p != 2, p != 1};
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        {pr, ar, pe, ae, cal, cmp, seen, mpr, mar} = '0;
        cnt = 0;
        ps = {9'h000, $signed(primary_accumulator) >
              $signed(accumulator_threshold_reg), 6'h00};
        @(negedge ref_clk);
        chk(converter_status, 16'h0000);
    endtask
    // One random burst of events, then the model and the compare
    task automatic step;
        r = $random(seed);
        q = $random(seed);
        pv = {r[0], r[1] & r[2], r[1] & ~r[2], q[23:0]};
        av = {r[3], r[4] & r[5], r[4] & ~r[5], q[31:8]};
        @(posedge ref_clk);
        {prim_conv, aux_conv} <= {pv, av};
        {cal_done, mode_reg_write} <= {&r[10:8], &r[12:11]};
        {aux_result_read, primary_result_read} <= r[7:6];
        core_powered_down <= &r[14:13];
        converter_irq_mask <= r[23:16];
        cmp_cfg.comp_threshold <= {1'b0, r[31:9]};
        primary_accumulator <= $random(seed);
        accumulator_threshold_reg <= $random(seed);
        @(posedge ref_clk);
        {prim_conv.valid, aux_conv.valid, cal_done, mode_reg_write} <= '0;
        {aux_result_read, primary_result_read} <= '0;
        // Hold decision uses the flags from before this edge
        wp = pv.valid && (!pr || &r[14:13]);
        wa = av.valid && (!ar || &r[14:13]);
        ex = pv.valid && (mag(clamp(pv[25:0])) > {1'b0, r[31:9]});
        if (p == 1 && ex && cnt < 3) cnt++;
        if (pv.valid && p != 2) cmp = (p == 0) ? ex : (cnt == 3);
        if (r[6]) {pr, seen, ar} = {2'b00, ar & !seen};
        else if (r[7]) seen = 1'b1;
        if (wp) {mpr, pe} = {clamp(pv[25:0]), |pv[25:24]};
        if (wp && prim_enable) pr = 1'b1;
        if (wa) {mar, ae} = {clamp(av[25:0]), |av[25:24]};
        if (wa && aux_enable) ar = 1'b1;
        if (&r[12:11]) cal = 1'b0;
        if (&r[10:8]) {cal, pr, ar} = 3'b111;
        @(negedge ref_clk);
        es = {cal, 1'b0, ae, pe, 5'h00, $signed(primary_accumulator) >
              $signed(accumulator_threshold_reg), 1'b0, cmp, 2'b00, ar, pr};
        chk(converter_status[15:12], es[15:12]);
        chk(converter_status[11:4], es[11:4]);
        chk(converter_status[3:0], es[3:0]);
        chk(primary_result_reg, mpr);
        chk(aux_result_reg, mar);
        chk(threshold_counter_value, cnt[15:0]);
        chk(converter_irq, |(ps[7:0] & r[23:16]));
        ps = es;
    endtask
    // Waits for the overrange flag, giving up after 1300 cycles
    task automatic wait_ovr(input logic v);
        n = 0;
        while (converter_status[3] !== v && n < 1300) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    // Pin high sets the flag at a period edge; it sticks until gain change
    task automatic ovr_test;
        @(posedge ref_clk);
        {ovr_detect_enable, gross_overrange_in} <= 2'b11;
        wait_ovr(1'b1);
        chk(n < 1260, 1);
        t0 = cyc;
        @(posedge ref_clk);
        gross_overrange_in <= 1'b0;
        wait_ovr(1'b0);
        chk(converter_status[3], 1'b1);
        @(posedge ref_clk);
        {gross_overrange_in, gain_change} <= 2'b11;
        @(posedge ref_clk);
        gain_change <= 1'b0;
        @(negedge ref_clk);
        chk(converter_status[3], 1'b0);
        wait_ovr(1'b1);
        chk((cyc - t0) % 1250, 0);
    endtask
    initial begin
        rst_n = 1'b0;
        {cal_done, mode_reg_write, gain_change, core_powered_down} = '0;
        {prim_enable, aux_enable} = '0;
        {aux_result_read, primary_result_read, ovr_detect_enable} = '0;
        {gross_overrange_in, prim_conv, aux_conv, converter_irq_mask} = '0;
        {primary_accumulator, accumulator_threshold_reg, cmp_cfg} = '0;
        for (p = 0; p < 3; p++) begin
            rst_seq;
            repeat (100) step;
        end
        ovr_test;
        report_and_stop;
    end
    // The run needs under 5000 cycles; this cuts a hang short
    initial begin
        #2000000;
        fail_count++;
        report_and_stop;
    end
endmodule
